// File: design/pvh_pkg.sv
// shared constants and types for the video input and host control front end
package pvh_pkg;
    localparam logic [6:0] ADDR_LO_A = 7'h34;
    localparam logic [6:0] ADDR_LO_B = 7'h35;
    localparam logic [6:0] ADDR_HI_A = 7'h3a;
    localparam logic [6:0] ADDR_HI_B = 7'h3b;
    localparam logic [6:0] PERIPH_ADDR = 7'h60;
    localparam logic [7:0] CMD_STATUS = 8'h00;
    localparam logic [7:0] CMD_LED = 8'h01;
    localparam int CHAN_W = 10;
    localparam int PIX_W = 30;
    localparam int PAT_MSB = 8;
    localparam int LANES = 5;
    localparam int LANE_BITS = 7;
    localparam logic [2:0] LANE_LAST = 3'h6;
    localparam logic [1:0] LW_24 = 2'h0;
    localparam logic [1:0] LW_27 = 2'h1;
    localparam logic [1:0] LW_30 = 2'h2;
    localparam logic [3:0] INIT_CYC = 4'h8;
    localparam int CLK_MHZ = 100;
    localparam int I2C_KHZ = 400;
    localparam logic [7:0] QTR_CYC = 8'((CLK_MHZ * 1000) / (I2C_KHZ * 4));
    localparam logic [4:0] MST_LAST = 5'h11;
    typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_AACK, SL_WR, SL_WACK, SL_RD, SL_RACK}
        pvh_sl_st_t;
    typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} pvh_m_st_t;
endpackage

// File: design/pvh_i2c_slave.sv
// two-wire control slave with a strap-selected address pair
module pvh_i2c_slave (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic addrHi,
    input wire logic [7:0] rdData,
    output logic sdaOe,
    output logic wrStb,
    output logic wrFirst,
    output logic [7:0] wrData,
    output logic rdStb
);
    import pvh_pkg::*;
    typedef struct packed {
        logic [1:0] scl;
        logic [1:0] sda;
        logic sclP;
        logic sdaP;
        pvh_sl_st_t st;
        logic [7:0] sh;
        logic [2:0] cnt;
        logic rw;
        logic first;
        logic oe;
        logic wrStb;
        logic rdStb;
    } pvh_sl_t;
    pvh_sl_t q, n;
    logic sclS, sdaS, rise, fall, start, stop;
    logic [7:0] byteIn;
    logic [6:0] addrA, addrB;

    assign sclS = q.scl[1];
    assign sdaS = q.sda[1];
    assign rise = sclS & ~q.sclP;
    assign fall = ~sclS & q.sclP;
    assign start = sclS & q.sclP & ~sdaS & q.sdaP;
    assign stop = sclS & q.sclP & sdaS & ~q.sdaP;
    assign byteIn = {q.sh[6:0], sdaS};
    assign addrA = addrHi ? ADDR_HI_A : ADDR_LO_A;
    assign addrB = addrHi ? ADDR_HI_B : ADDR_LO_B;

    always_comb begin
        n = q;
        n.scl = {q.scl[0], sclIn};
        n.sda = {q.sda[0], sdaIn};
        n.sclP = sclS;
        n.sdaP = sdaS;
        n.wrStb = 1'b0;
        n.rdStb = 1'b0;
        if (start) begin
            n.st = SL_ADDR;
            n.cnt = 3'h0;
            n.oe = 1'b0;
            n.first = 1'b1;
        end else if (stop) begin
            n.st = SL_IDLE;
            n.oe = 1'b0;
        end else begin
            case (q.st)
                SL_ADDR: if (rise) begin
                    n.sh = byteIn;
                    n.cnt = q.cnt + 3'h1;
                    if (q.cnt == 3'h7) begin
                        if (byteIn[7:1] == addrA || byteIn[7:1] == addrB) begin
                            n.st = SL_AACK;
                            n.rw = byteIn[0];
                            n.rdStb = byteIn[0];
                        end else begin
                            n.st = SL_IDLE;
                        end
                    end
                end
                SL_AACK, SL_WACK: if (fall) begin
                    if (!q.oe) begin
                        n.oe = 1'b1;
                    end else if (q.st == SL_AACK && q.rw) begin
                        n.st = SL_RD;
                        n.sh = rdData;
                        n.oe = ~rdData[7];
                        n.cnt = 3'h0;
                    end else begin
                        n.st = SL_WR;
                        n.oe = 1'b0;
                        n.cnt = 3'h0;
                    end
                end
                SL_WR: if (rise) begin
                    n.sh = byteIn;
                    n.cnt = q.cnt + 3'h1;
                    if (q.cnt == 3'h7) begin
                        n.st = SL_WACK;
                        n.wrStb = 1'b1;
                    end
                end
                SL_RD: if (rise) begin
                    n.cnt = q.cnt + 3'h1;
                end else if (fall) begin
                    if (q.cnt == 3'h0) begin
                        n.st = SL_RACK;
                        n.oe = 1'b0;
                    end else begin
                        n.sh = {q.sh[6:0], 1'b0};
                        n.oe = ~q.sh[6];
                    end
                end
                SL_RACK: if (rise) begin
                    if (sdaS) begin
                        n.st = SL_IDLE;
                    end else begin
                        n.rdStb = 1'b1;
                        n.cnt = 3'h1;
                    end
                end else if (fall && q.cnt == 3'h1) begin
                    n.st = SL_RD;
                    n.sh = rdData;
                    n.oe = ~rdData[7];
                    n.cnt = 3'h0;
                end
                default: n.st = SL_IDLE;
            endcase
        end
        if (q.wrStb && !start) begin
            n.first = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '{scl: 2'h3, sda: 2'h3, sclP: 1'b1, sdaP: 1'b1, st: SL_IDLE,
                   sh: 8'h00, cnt: 3'h0, rw: 1'b0, first: 1'b0, oe: 1'b0,
                   wrStb: 1'b0, rdStb: 1'b0};
        end else begin
            q <= n;
        end
    end

    assign sdaOe = q.oe;
    assign wrStb = q.wrStb;
    assign wrFirst = q.first;
    assign wrData = q.sh;
    assign rdStb = q.rdStb;

    AST_ADDR_LO: assert property (@(posedge mclk) disable iff (!rstn)
        (q.st == SL_AACK && $past(q.st) == SL_ADDR && !addrHi) |-> q.sh[7:2] == ADDR_LO_A[6:1])
        else $error("slave matched outside low address pair");
    AST_ADDR_HI: assert property (@(posedge mclk) disable iff (!rstn)
        (q.st == SL_AACK && $past(q.st) == SL_ADDR && addrHi) |-> q.sh[7:2] == ADDR_HI_A[6:1])
        else $error("slave matched outside high address pair");
endmodule // pvh_i2c_slave

// File: design/pvh_i2c_master.sv
// two-wire master that writes one byte to an on-board peripheral
module pvh_i2c_master (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic go,
    input wire logic [7:0] data,
    output logic sclOe,
    output logic sdaOe,
    output logic busy
);
    import pvh_pkg::*;
    typedef struct packed {
        pvh_m_st_t st;
        logic [7:0] div;
        logic [1:0] ph;
        logic [4:0] bitCnt;
        logic [17:0] sh;
        logic sclOe;
        logic sdaOe;
    } pvh_m_t;
    pvh_m_t q, n;
    logic tick;

    assign tick = (q.div == QTR_CYC);

    always_comb begin
        n = q;
        n.div = (q.st == M_IDLE || tick) ? 8'h00 : q.div + 8'h01;
        case (q.st)
            M_IDLE: if (go) begin
                n.st = M_START;
                n.sh = {PERIPH_ADDR, 1'b0, 1'b1, data, 1'b1};
                n.bitCnt = 5'h00;
                n.ph = 2'h0;
            end
            M_START: if (tick) begin
                n.sdaOe = 1'b1;
                n.ph = q.ph + 2'h1;
                if (q.ph == 2'h1) begin
                    n.sclOe = 1'b1;
                    n.st = M_BIT;
                    n.ph = 2'h0;
                end
            end
            M_BIT: if (tick) begin
                n.ph = q.ph + 2'h1;
                case (q.ph)
                    2'h0: n.sdaOe = ~q.sh[17];
                    2'h1: n.sclOe = 1'b0;
                    2'h2: n.sclOe = 1'b0;
                    default: begin
                        n.sclOe = 1'b1;
                        n.sh = {q.sh[16:0], 1'b1};
                        n.bitCnt = q.bitCnt + 5'h01;
                        if (q.bitCnt == MST_LAST) begin
                            n.st = M_STOP;
                        end
                    end
                endcase
            end
            M_STOP: if (tick) begin
                n.ph = q.ph + 2'h1;
                case (q.ph)
                    2'h0: n.sdaOe = 1'b1;
                    2'h1: n.sclOe = 1'b0;
                    default: begin
                        n.sdaOe = 1'b0;
                        n.st = M_IDLE;
                    end
                endcase
            end
            default: n.st = M_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '{st: M_IDLE, div: 8'h00, ph: 2'h0, bitCnt: 5'h00, sh: 18'h00000,
                   sclOe: 1'b0, sdaOe: 1'b0};
        end else begin
            q <= n;
        end
    end

    assign sclOe = q.sclOe;
    assign sdaOe = q.sdaOe;
    assign busy = (q.st != M_IDLE);
endmodule // pvh_i2c_master

// File: design/pvh_video_ctrl.sv
// video input ports, strap capture and host command handling
module pvh_video_ctrl (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic addrSelIn,
    input wire logic supplyOkIn,
    input wire logic positionSenseIn,
    input wire logic hostCtrlSclIn,
    input wire logic hostCtrlSdaIn,
    output logic hostCtrlSclOut,
    output logic hostCtrlSclOe,
    output logic hostCtrlSdaOut,
    output logic hostCtrlSdaOe,
    output logic periphCtrlSclOut,
    output logic periphCtrlSclOe,
    output logic periphCtrlSdaOut,
    output logic periphCtrlSdaOe,
    input wire logic pixelClkIn,
    input wire logic frameSyncIn,
    input wire logic lineSyncIn,
    input wire logic pixelValidIn,
    input wire logic [pvh_pkg::PIX_W-1:0] rgbPixelBus,
    input wire logic patternMode,
    input wire logic [1:0] chanMap,
    input wire logic lvdsClkPair,
    input wire logic [pvh_pkg::LANES-1:0] lvdsLanes,
    input wire logic [1:0] lvdsWidth,
    output logic [pvh_pkg::PIX_W-1:0] pixWord,
    output logic pixStb,
    output logic frameStart,
    output logic lineStart,
    output logic [pvh_pkg::PIX_W-1:0] lvdsWord,
    output logic lvdsStb,
    output logic initDone,
    output logic strapHi,
    output logic usbSerialSel,
    output logic gpioIn,
    output logic sysReady,
    output logic [7:0] ledCurrent
);
    import pvh_pkg::*;
    localparam int PIN_W = PIX_W + 3;

    typedef struct packed {
        logic [1:0] strap;
        logic [1:0] okSync;
        logic [1:0] posSync;
        logic [1:0] pclk;
        logic pclkP;
        logic [PIN_W-1:0] pin1;
        logic [PIN_W-1:0] pin2;
        logic [PIN_W-1:0] pin3;
        logic frameP;
        logic lineP;
        logic [1:0] lclk;
        logic lclkP;
        logic [LANES-1:0] lane1;
        logic [LANES-1:0] lane2;
        logic [LANES-1:0] lane3;
        logic [2:0] bitCnt;
        logic [LANES*LANE_BITS-1:0] lsh;
        logic [3:0] initCnt;
        logic initDone;
        logic strapHi;
        logic usbSel;
        logic gpio;
        logic ready;
        logic [7:0] cmdIdx;
        logic [7:0] led;
        logic [7:0] rdData;
        logic mstGo;
        logic [PIX_W-1:0] pixWord;
        logic pixStb;
        logic frameStart;
        logic lineStart;
        logic [PIX_W-1:0] lvdsWord;
        logic lvdsStb;
    } pvh_top_t;
    pvh_top_t q, n;

    logic slvSdaOe, wrStb, wrFirst, rdStb, mstSclOe, mstSdaOe, mstBusy;
    logic [7:0] wrData;
    logic pixRise, lvdsRise;
    logic [CHAN_W-1:0] chA, chB, chC;
    logic [LANES*LANE_BITS-1:0] lvdsCat;
    logic [PIX_W-1:0] mapped;

    // remap of the three colour channel groups
    function automatic logic [PIX_W-1:0] remap(input logic [PIX_W-1:0] bus,
                                               input logic [1:0] sel);
        logic [CHAN_W-1:0] a, b, c;
        a = bus[CHAN_W-1:0];
        b = bus[2*CHAN_W-1:CHAN_W];
        c = bus[3*CHAN_W-1:2*CHAN_W];
        case (sel)
            2'h1: remap = {a, c, b};
            2'h2: remap = {b, a, c};
            2'h3: remap = {a, b, c};
            default: remap = {c, b, a};
        endcase
    endfunction

    // keeps only the bits of the configured serial word width
    function automatic logic [PIX_W-1:0] widthMask(input logic [1:0] w);
        case (w)
            LW_27: widthMask = {{(PIX_W-27){1'b0}}, {27{1'b1}}};
            LW_30: widthMask = {PIX_W{1'b1}};
            default: widthMask = {{(PIX_W-24){1'b0}}, {24{1'b1}}};
        endcase
    endfunction

    // ------------------------------------------------------------
    // host and peripheral control ports
    // ------------------------------------------------------------
    pvh_i2c_slave u_slave (
        .mclk(mclk),
        .rstn(rstn),
        .sclIn(hostCtrlSclIn),
        .sdaIn(hostCtrlSdaIn),
        .addrHi(q.strapHi),
        .rdData(q.rdData),
        .sdaOe(slvSdaOe),
        .wrStb(wrStb),
        .wrFirst(wrFirst),
        .wrData(wrData),
        .rdStb(rdStb)
    );

    pvh_i2c_master u_master (
        .mclk(mclk),
        .rstn(rstn),
        .go(q.mstGo),
        .data(q.led),
        .sclOe(mstSclOe),
        .sdaOe(mstSdaOe),
        .busy(mstBusy)
    );

    assign pixRise = q.pclk[1] & ~q.pclkP;
    assign lvdsRise = q.lclk[1] & ~q.lclkP;
    // data one stage older than the clock view: value before the edge
    assign mapped = remap(q.pin3[PIX_W-1:0], chanMap);
    assign chA = mapped[CHAN_W-1:0];
    assign chB = mapped[2*CHAN_W-1:CHAN_W];
    assign chC = mapped[3*CHAN_W-1:2*CHAN_W];
    assign lvdsCat = q.lsh;

    always_comb begin
        n = q;
        n.strap = {q.strap[0], addrSelIn};
        n.okSync = {q.okSync[0], supplyOkIn};
        n.posSync = {q.posSync[0], positionSenseIn};
        n.pclk = {q.pclk[0], pixelClkIn};
        n.pclkP = q.pclk[1];
        n.pin1 = {pixelValidIn, lineSyncIn, frameSyncIn, rgbPixelBus};
        n.pin2 = q.pin1;
        n.pin3 = q.pin2;
        n.lclk = {q.lclk[0], lvdsClkPair};
        n.lclkP = q.lclk[1];
        n.lane1 = lvdsLanes;
        n.lane2 = q.lane1;
        n.lane3 = q.lane2;
        n.mstGo = 1'b0;
        n.pixStb = 1'b0;
        n.frameStart = 1'b0;
        n.lineStart = 1'b0;
        n.lvdsStb = 1'b0;
        n.ready = q.okSync[1] & q.posSync[1];

        // ------------------------------------------------------------
        // strap capture after reset release
        // ------------------------------------------------------------
        if (!q.initDone) begin
            n.initCnt = q.initCnt + 4'h1;
            if (q.initCnt == INIT_CYC) begin
                n.initDone = 1'b1;
                n.strapHi = q.strap[1];
                n.usbSel = q.strap[1];
            end
        end else begin
            n.gpio = q.strap[1];
        end

        // ------------------------------------------------------------
        // host commands
        // ------------------------------------------------------------
        if (wrStb) begin
            if (wrFirst) begin
                n.cmdIdx = wrData;
            end else if (q.cmdIdx == CMD_LED) begin
                n.led = wrData;
                n.mstGo = ~mstBusy;
            end
        end
        if (rdStb) begin
            case (q.cmdIdx)
                CMD_STATUS: n.rdData = {4'h0, mstBusy, q.strapHi, q.initDone, q.ready};
                CMD_LED: n.rdData = q.led;
                default: n.rdData = 8'h00;
            endcase
        end

        // ------------------------------------------------------------
        // parallel pixel port
        // ------------------------------------------------------------
        if (pixRise && q.ready) begin
            n.frameP = q.pin3[PIX_W];
            n.lineP = q.pin3[PIX_W+1];
            n.frameStart = q.pin3[PIX_W] & ~q.frameP;
            n.lineStart = q.pin3[PIX_W+1] & ~q.lineP;
            if (q.pin3[PIX_W+2]) begin
                n.pixStb = 1'b1;
                if (patternMode) begin
                    n.pixWord = {6'h00, chC[CHAN_W-1 -: PAT_MSB], chB[CHAN_W-1 -: PAT_MSB],
                                 chA[CHAN_W-1 -: PAT_MSB]};
                end else begin
                    n.pixWord = {chC, chB, chA};
                end
            end
        end

        // ------------------------------------------------------------
        // serial video port, one bit per lane per rising clock edge
        // ------------------------------------------------------------
        if (lvdsRise && q.ready) begin
            for (int i = 0; i < LANES; i++) begin
                n.lsh[i*LANE_BITS +: LANE_BITS] =
                    {q.lsh[i*LANE_BITS +: LANE_BITS-1], q.lane3[i]};
            end
            n.bitCnt = (q.bitCnt == LANE_LAST) ? 3'h0 : q.bitCnt + 3'h1;
            if (q.bitCnt == LANE_LAST) begin
                n.lvdsStb = 1'b1;
            end
        end
        if (q.lvdsStb) begin
            n.lvdsWord = lvdsCat[PIX_W-1:0] & widthMask(lvdsWidth);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign hostCtrlSclOut = 1'b0;
    assign hostCtrlSclOe = 1'b0;
    assign hostCtrlSdaOut = 1'b0;
    assign hostCtrlSdaOe = slvSdaOe;
    assign periphCtrlSclOut = 1'b0;
    assign periphCtrlSclOe = mstSclOe;
    assign periphCtrlSdaOut = 1'b0;
    assign periphCtrlSdaOe = mstSdaOe;
    assign pixWord = q.pixWord;
    assign pixStb = q.pixStb;
    assign frameStart = q.frameStart;
    assign lineStart = q.lineStart;
    assign lvdsWord = q.lvdsWord;
    assign lvdsStb = q.lvdsStb;
    assign initDone = q.initDone;
    assign strapHi = q.strapHi;
    assign usbSerialSel = q.usbSel;
    assign gpioIn = q.gpio;
    assign sysReady = q.ready;
    assign ledCurrent = q.led;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_STRAP_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
        $past(q.initDone) |-> $stable(q.strapHi))
        else $error("strap choice changed after init");
    AST_SERIAL: assert property (@(posedge mclk) disable iff (!rstn)
        q.initDone |-> q.usbSel == q.strapHi)
        else $error("usb serial select differs from strap");
    AST_GPIO: assert property (@(posedge mclk) disable iff (!rstn)
        !q.initDone |-> !q.gpio)
        else $error("pin released before init");
    AST_LED: assert property (@(posedge mclk) disable iff (!rstn)
        (wrStb && !wrFirst && q.cmdIdx == CMD_LED) |=> q.led == $past(wrData))
        else $error("led current not taken from host");
    AST_PIX_VALID: assert property (@(posedge mclk) disable iff (!rstn)
        q.pixStb |-> $past(pixRise) && $past(q.pin3[PIX_W+2]) && $past(q.ready))
        else $error("pixel strobe without valid");
    AST_PATTERN: assert property (@(posedge mclk) disable iff (!rstn)
        (q.pixStb && patternMode && $past(patternMode)) |-> q.pixWord[PIX_W-1:24] == 6'h00)
        else $error("pattern word wider than 24 bits");
    AST_FRAME: assert property (@(posedge mclk) disable iff (!rstn)
        q.frameStart |-> $past(pixRise) && $past(q.pin3[PIX_W]) && !$past(q.frameP))
        else $error("frame start without sync edge");
    AST_LVDS_CNT: assert property (@(posedge mclk) disable iff (!rstn)
        q.lvdsStb |-> $past(q.bitCnt) == LANE_LAST && $past(lvdsRise))
        else $error("serial word not after seven bits");
    AST_LVDS_W: assert property (@(posedge mclk) disable iff (!rstn)
        ($past(q.lvdsStb) && $past(lvdsWidth) == LW_24) |-> q.lvdsWord[PIX_W-1:24] == 6'h00)
        else $error("serial word exceeds 24 bits");
    AST_READY: assert property (@(posedge mclk) disable iff (!rstn)
        !$past(q.ready) |-> !q.pixStb && !q.lvdsStb)
        else $error("video output while not ready");
endmodule // pvh_video_ctrl

// File: tb/pvh_src_model.sv
// video source model driving the parallel and serial input ports
module pvh_src_model (
    input wire logic mclk,
    output logic pixelClkIn,
    output logic frameSyncIn,
    output logic lineSyncIn,
    output logic pixelValidIn,
    output logic [29:0] rgbPixelBus,
    output logic lvdsClkPair,
    output logic [4:0] lvdsLanes
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {pixelClkIn, frameSyncIn, lineSyncIn, pixelValidIn, lvdsClkPair} = 5'h00;
        rgbPixelBus = 30'h0;
        lvdsLanes = 5'h00;
    end
    // one pixel clock period, inputs set up before the rising edge
    task pix(input logic f, input logic l, input logic v, input logic [29:0] d);
        @(posedge mclk);
        #1;
        frameSyncIn = f;
        lineSyncIn = l;
        pixelValidIn = v;
        rgbPixelBus = d;
        repeat (4) @(posedge mclk);
        #1;
        pixelClkIn = 1'b1;
        @(posedge mclk);
        #1;
        rgbPixelBus = ~d;
        repeat (4) @(posedge mclk);
        #1;
        {pixelClkIn, frameSyncIn, lineSyncIn, pixelValidIn} = 4'h0;
        repeat (4) @(posedge mclk);
    endtask
    // seven link clocks, msb of each lane first; clock idle between words
    task ser(input logic [34:0] w);
        for (int b = 6; b >= 0; b--) begin
            for (int i = 0; i < 5; i++) lvdsLanes[i] = w[i*7+b];
            #31;
            lvdsClkPair = 1'b1;
            #62.5;
            lvdsClkPair = 1'b0;
            #31.5;
        end
        lvdsLanes = ~lvdsLanes;
    endtask
endmodule // pvh_src_model

// File: tb/tb.sv
// self-checking bench for the video input and host control front end
module tb import pvh_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 0, rstn = 0, addrSelIn = 0, supplyOkIn = 1, positionSenseIn = 1;
    logic scl = 1, sda = 1, patternMode = 0, ak;
    logic pScl, pSda, pP = 0;
    logic [7:0] rv;
    logic [18:0] pSh = '0;
    logic [1:0] chanMap = 2'h0, lvdsWidth = 2'h0;
    wire logic pixelClkIn, frameSyncIn, lineSyncIn, pixelValidIn, lvdsClkPair;
    wire logic [29:0] rgbPixelBus;
    wire logic [4:0] lvdsLanes;
    logic hostCtrlSdaOe, pixStb, frameStart, lineStart, lvdsStb, initDone, strapHi;
    logic usbSerialSel, gpioIn, sysReady, sDly = 0;
    logic [29:0] pixWord, lvdsWord, lastPix, lastSer, d, ex[4];
    logic [7:0] ledCurrent;
    logic [6:0] adr[4] = '{7'h34, 7'h35, 7'h3a, 7'h3b};
    logic [34:0] w = 35'h5_a3c9_6e1b;
    int bad_count = 0, n_tests = 0, nPix = 0, nLn = 0, nSer = 0, k;
    always #5 mclk = ~mclk;
    pvh_src_model pvh_src_model_inst (.mclk, .pixelClkIn, .frameSyncIn, .lineSyncIn,
        .pixelValidIn, .rgbPixelBus, .lvdsClkPair, .lvdsLanes);
    pvh_video_ctrl pvh_video_ctrl_inst (.mclk, .rstn, .addrSelIn, .supplyOkIn,
        .positionSenseIn, .hostCtrlSclIn(scl), .hostCtrlSdaIn(sda & ~hostCtrlSdaOe),
        .hostCtrlSclOut(), .hostCtrlSclOe(), .hostCtrlSdaOut(), .hostCtrlSdaOe,
        .periphCtrlSclOut(), .periphCtrlSclOe(pScl), .periphCtrlSdaOut(), .periphCtrlSdaOe(pSda),
        .pixelClkIn, .frameSyncIn, .lineSyncIn, .pixelValidIn, .rgbPixelBus, .patternMode,
        .chanMap, .lvdsClkPair, .lvdsLanes, .lvdsWidth, .pixWord, .pixStb, .frameStart,
        .lineStart, .lvdsWord, .lvdsStb, .initDone, .strapHi, .usbSerialSel, .gpioIn,
        .sysReady, .ledCurrent);
    always @(posedge mclk) begin
        if (pixStb === 1'b1) begin
            nPix++;
            lastPix = pixWord;
        end
        if (lineStart === 1'b1) nLn++;
        if (sDly) begin
            nSer++;
            lastSer = lvdsWord;
        end
        sDly <= (lvdsStb === 1'b1);
        if (pP && !pScl) pSh = {pSh[17:0], ~pSda};
        pP <= pScl;
    end
    task chk(input logic [29:0] g, input logic [29:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task end_of_test;
        if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // two-wire host: pins change then hold 9 cycles
    // ----------------------------------------
    task sw(input logic c, input logic v);
        @(posedge mclk);
        #1;
        scl = c;
        sda = v;
        repeat (8) @(posedge mclk);
    endtask
    task bt(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sw(0, b[i]);
            sw(1, b[i]);
            sw(0, b[i]);
        end
        sw(0, 1);
        ak = hostCtrlSdaOe;
        sw(1, 1);
        sw(0, 1);
    endtask
    task wr(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int n);
        sw(1, 1);
        sw(1, 0);
        sw(0, 0);
        bt(b0);
        if (n > 1) bt(b1);
        if (n > 2) bt(b2);
        sw(0, 0);
        sw(1, 0);
        sw(1, 1);
    endtask
    task rd(input logic [7:0] a, output logic [7:0] r);
        sw(1, 1);
        sw(1, 0);
        sw(0, 0);
        bt(a);
        for (int i = 7; i >= 0; i--) begin
            sw(0, 1);
            sw(1, 1);
            r[i] = ~hostCtrlSdaOe;
        end
        sw(0, 1);
        sw(1, 1);
        sw(0, 0);
        sw(1, 0);
        sw(1, 1);
    endtask
    initial begin
        for (int s = 0; s < 2; s++) begin
            #1;
            rstn = 0;
            addrSelIn = s[0];
            repeat (8) @(posedge mclk);
            #1;
            rstn = 1;
            k = 0;
            while (initDone !== 1'b1 && k < 100) begin
                @(posedge mclk);
                k++;
            end
            if (k == 100) begin
                bad_count++;
                end_of_test;
            end
            #1;
            addrSelIn = ~s[0];
            repeat (6) @(posedge mclk);
            chk(strapHi, 30'(s));
            chk(usbSerialSel, 30'(s));
            chk(gpioIn, 30'(1 - s));
            for (int j = 0; j < 4; j++) begin
                wr({adr[j], 1'b0}, 8'h00, 8'h00, 1);
                chk(ak, 30'((j / 2) == s));
            end
        end
        wr({ADDR_HI_A, 1'b0}, CMD_LED, 8'ha5, 3);
        chk(ledCurrent, 30'h0000a5);
        rd({ADDR_HI_B, 1'b1}, rv);
        chk(rv, 30'h0000a5);
        d = {10'h1f3, 10'h2a7, 10'h3c5};
        ex = '{d, {d[9:0], d[29:20], d[19:10]}, {d[19:10], d[9:0], d[29:20]},
            {d[9:0], d[19:10], d[29:20]}};
        pvh_src_model_inst.pix(1, 1, 1, d);
        chk(nPix, 30'h1);
        chk(lastPix, d);
        for (int m = 0; m < 4; m++) begin
            chanMap = m[1:0];
            pvh_src_model_inst.pix(0, 0, 1, d);
            chk(lastPix, ex[m]);
        end
        pvh_src_model_inst.pix(0, 1, 0, d);
        chk(nPix, 30'h5);
        chk(nLn, 30'h2);
        chanMap = 2'h0;
        patternMode = 1;
        pvh_src_model_inst.pix(0, 0, 1, d);
        chk(lastPix, {6'h00, d[29:22], d[19:12], d[9:2]});
        supplyOkIn = 0;
        repeat (6) @(posedge mclk);
        chk(sysReady, 30'h0);
        pvh_src_model_inst.pix(0, 0, 1, d);
        chk(nPix, 30'h6);
        supplyOkIn = 1;
        repeat (6) @(posedge mclk);
        chk(sysReady, 30'h1);
        for (int v = 0; v < 3; v++) begin
            lvdsWidth = v[1:0];
            pvh_src_model_inst.ser(w);
            repeat (10) @(posedge mclk);
            chk(lastSer, w[29:0] & 30'((35'h1 << (24 + 3 * v)) - 1));
            chk(nSer, 30'(v + 1));
        end
        repeat (5000) @(posedge mclk);
        chk(30'(pSh), 30'({PERIPH_ADDR, 2'h1, 8'ha5, 2'h2}));
        end_of_test;
    end
endmodule // tb
